// file: logic/wtb_pkg.sv
// Constants and the control register layout of the watch timer with buzzer.
// Assumes one system clock (fxx) and a sub-system clock pin sampled in that domain.
package wtb_pkg;
    localparam logic [7:0] WTB_CTRL_ADDR = 8'hE6; // watch_timer_control offset
    localparam logic [7:0] WTB_CTRL_RESET = 8'h00;
    localparam int WTB_BIT_CLK_SEL = 7;
    localparam int WTB_BIT_INT_EN = 6;
    localparam int WTB_BIT_BUZ_LSB = 4;
    localparam int WTB_BIT_SPD_LSB = 2;
    localparam int WTB_BIT_ENABLE = 1;
    localparam int WTB_BIT_PEND = 0;
    // Main clock prescale to the watch clock: fxx / 2^7
    localparam int WTB_PRESCALE_DIV = 128;
    localparam int WTB_PRESCALE_W = 7;
    localparam logic [6:0] WTB_PRESCALE_LAST = 7'(WTB_PRESCALE_DIV - 1);
    // Watch clock nominal 32768 Hz; divider width covers the longest interval
    localparam int WTB_WATCH_HZ = 32768;
    localparam int WTB_DIV_W = 14;
    // Interval lengths in watch clock ticks: 0.5 s, 0.25 s, 0.125 s, 1.95 ms
    localparam int WTB_IVL_TICKS_0 = WTB_WATCH_HZ / 2;
    localparam int WTB_IVL_TICKS_1 = WTB_WATCH_HZ / 4;
    localparam int WTB_IVL_TICKS_2 = WTB_WATCH_HZ / 8;
    localparam int WTB_IVL_TICKS_3 = 64;
    // Buzzer 0.5 kHz is watch clock / 64, so divider bit 5; each code step halves
    localparam int WTB_BUZ_BASE_BIT = 5;

    typedef struct packed {
        logic clk_sel;      // 0: fxx/128, 1: sub clock
        logic int_en;
        logic [1:0] buz_sel;
        logic [1:0] spd_sel;
        logic enable;
        logic pend;
    } wtb_ctrl_t;
endpackage

// file: logic/wtb_watch_timer.sv
// Watch timer with buzzer output, controlled by one 8-bit register.
// Assumes a register-addressed write/read port in the clk_sys domain and an asynchronous sub clock pin.
// How it works
// - Count clock is fxx/128 when select is 0, sub clock when 1.
// - Interrupt request leaves only while interrupt enable is 1.
// - Buzzer codes 00..11 give 0.5, 1, 2 and 4 kHz.
// - Speed codes 00..11 give 0.5 s, 0.25 s, 0.125 s, 1.95 ms intervals.
// - Pending bit reads 1 while pending; writing 0 clears it.
// - Intervals and tones come from dividing a nominal 32.768 kHz watch clock.
`timescale 1ns/1ps
module wtb_watch_timer (
    input wire logic clk_sys,        // System clock fxx, 50 MHz
    input wire logic rst_n,          // Asynchronous reset, active low
    input wire logic sub_clk,        // Sub-system oscillator clock pin
    input wire logic [7:0] reg_addr, // Register address
    input wire logic reg_wr,         // Write strobe, one cycle
    input wire logic [7:0] reg_wdata, // Write data
    input wire logic reg_rd,         // Read strobe, one cycle
    output logic [7:0] reg_rdata,    // Read data, valid the cycle after reg_rd
    output logic irq,                // Watch timer interrupt request
    output logic buzzer              // Buzzer tone output
);
    logic rst_s1;
    logic rst_s2;
    logic sub_s1;
    logic sub_s2;
    logic sub_s3;
    logic [6:0] presc;
    logic [13:0] div_cnt;
    logic tick;
    logic wrap;
    logic sub_rise;
    logic ctrl_hit;
    wtb_pkg::wtb_ctrl_t ctrl;

    // Reset released through two flops
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rst_s1 <= 1'b0;
            rst_s2 <= 1'b0;
        end else begin
            rst_s1 <= 1'b1;
            rst_s2 <= rst_s1;
        end
    end

    // Sub clock pin synchroniser; edge detect looks only at the second stage onward
    always_ff @(posedge clk_sys or negedge rst_s2) begin
        if (!rst_s2) begin
            sub_s1 <= 1'b0;
            sub_s2 <= 1'b0;
            sub_s3 <= 1'b0;
        end else begin
            sub_s1 <= sub_clk;
            sub_s2 <= sub_s1;
            sub_s3 <= sub_s2;
        end
    end

    assign sub_rise = sub_s2 && !sub_s3;
    assign ctrl_hit = (reg_addr == wtb_pkg::WTB_CTRL_ADDR);

    // Main clock prescaler; held at zero while disabled
    always_ff @(posedge clk_sys or negedge rst_s2) begin
        if (!rst_s2) begin
            presc <= '0;
        end else if (!ctrl.enable) begin
            presc <= '0;
        end else begin
            presc <= presc + 7'h01;
        end
    end

    // Watch clock tick: fxx/128 or a sub clock rising edge
    assign tick = ctrl.enable && (ctrl.clk_sel ? sub_rise : (presc == wtb_pkg::WTB_PRESCALE_LAST));

    // Divider chain of the watch clock
    always_ff @(posedge clk_sys or negedge rst_s2) begin
        if (!rst_s2) begin
            div_cnt <= '0;
        end else if (!ctrl.enable) begin
            div_cnt <= '0;
        end else if (tick) begin
            div_cnt <= div_cnt + 14'h0001;
        end
    end

    // Interval end: the low bits of the divider are about to roll over
    always_comb begin
        case (ctrl.spd_sel)
            2'h0: wrap = (div_cnt[13:0] == 14'(wtb_pkg::WTB_IVL_TICKS_0 - 1));
            2'h1: wrap = (div_cnt[12:0] == 13'(wtb_pkg::WTB_IVL_TICKS_1 - 1));
            2'h2: wrap = (div_cnt[11:0] == 12'(wtb_pkg::WTB_IVL_TICKS_2 - 1));
            default: wrap = (div_cnt[5:0] == 6'(wtb_pkg::WTB_IVL_TICKS_3 - 1));
        endcase
    end

    // Control register; a hardware set of pending wins over a clearing write
    always_ff @(posedge clk_sys or negedge rst_s2) begin
        if (!rst_s2) begin
            ctrl <= wtb_pkg::WTB_CTRL_RESET;
        end else begin
            if (reg_wr && ctrl_hit) begin
                ctrl.clk_sel <= reg_wdata[wtb_pkg::WTB_BIT_CLK_SEL];
                ctrl.int_en <= reg_wdata[wtb_pkg::WTB_BIT_INT_EN];
                ctrl.buz_sel <= reg_wdata[wtb_pkg::WTB_BIT_BUZ_LSB +: 2];
                ctrl.spd_sel <= reg_wdata[wtb_pkg::WTB_BIT_SPD_LSB +: 2];
                ctrl.enable <= reg_wdata[wtb_pkg::WTB_BIT_ENABLE];
            end
            if (tick && wrap) begin
                ctrl.pend <= 1'b1;
            end else if (reg_wr && ctrl_hit && !reg_wdata[wtb_pkg::WTB_BIT_PEND]) begin
                ctrl.pend <= 1'b0;
            end
        end
    end

    // Read data registered; other addresses read as zero
    always_ff @(posedge clk_sys or negedge rst_s2) begin
        if (!rst_s2) begin
            reg_rdata <= '0;
        end else if (reg_rd && ctrl_hit) begin
            reg_rdata <= ctrl;
        end else begin
            reg_rdata <= '0;
        end
    end

    // Buzzer tone from divider bit 5..2; low while disabled since the divider is cleared
    always_ff @(posedge clk_sys or negedge rst_s2) begin
        if (!rst_s2) begin
            buzzer <= 1'b0;
        end else begin
            buzzer <= div_cnt[wtb_pkg::WTB_BUZ_BASE_BIT - int'(ctrl.buz_sel)];
        end
    end

    assign irq = ctrl.pend && ctrl.int_en;

    sequence s_interval_end;
        tick && wrap;
    endsequence

    sequence s_pend_clear;
        reg_wr && ctrl_hit && !reg_wdata[wtb_pkg::WTB_BIT_PEND];
    endsequence

    AST_TICK_SOURCE: assert property (@(posedge clk_sys) disable iff (!rst_s2)
        tick |-> (ctrl.clk_sel ? sub_rise : presc == 7'h7F))
        else $error("watch tick from wrong clock source");


    // A rising request needs a cause one cycle back: an interval end or a register write
    AST_IRQ_GATE: assert property (@(posedge clk_sys) disable iff (!rst_s2)
        $rose(irq) |-> ctrl.int_en && ($past(tick && wrap) || $past(reg_wr && ctrl_hit)))
        else $error("interrupt request rose without a cause");

    AST_IRQ_OFF: assert property (@(posedge clk_sys) disable iff (!rst_s2)
        !ctrl.int_en |-> !irq)
        else $error("interrupt request while disabled");

    AST_BUZZER_TAP: assert property (@(posedge clk_sys) disable iff (!rst_s2)
        ##1 buzzer == $past(div_cnt[5 - int'(ctrl.buz_sel)]))
        else $error("buzzer not on selected divider bit");


    AST_INTERVAL_SET: assert property (@(posedge clk_sys) disable iff (!rst_s2)
        (s_interval_end and (ctrl.spd_sel == 2'h3 && div_cnt[5:0] == 6'h3F)) |=> ctrl.pend)
        else $error("short interval did not set pending");


    AST_PEND_CLEAR: assert property (@(posedge clk_sys) disable iff (!rst_s2)
        (s_pend_clear and !(tick && wrap)) |=> !ctrl.pend ##1 (ctrl.pend -> $past(tick && wrap)))
        else $error("pending bit not cleared by write of zero");

    AST_PEND_KEEP: assert property (@(posedge clk_sys) disable iff (!rst_s2)
        (ctrl.pend && reg_wr && ctrl_hit && reg_wdata[wtb_pkg::WTB_BIT_PEND]) |=> ctrl.pend)
        else $error("writing one to pending bit changed it");

    AST_PEND_HOLD: assert property (@(posedge clk_sys) disable iff (!rst_s2)
        (ctrl.pend && !(reg_wr && ctrl_hit)) |=> ctrl.pend)
        else $error("pending bit lost without a write");

    AST_READ_DATA: assert property (@(posedge clk_sys) disable iff (!rst_s2)
        (reg_rd && ctrl_hit) |=> reg_rdata == $past(ctrl))
        else $error("read data not the control value");

    AST_READ_OTHER: assert property (@(posedge clk_sys) disable iff (!rst_s2)
        (reg_rd && !ctrl_hit) |=> reg_rdata == 8'h00)
        else $error("unmapped address read not zero");


    AST_SET_WINS: assert property (@(posedge clk_sys) disable iff (!rst_s2)
        s_interval_end |=> ctrl.pend)
        else $error("interval event lost");

    AST_SUB_TICK: assert property (@(posedge clk_sys) disable iff (!rst_s2)
        (ctrl.enable && ctrl.clk_sel && sub_rise) |-> tick)
        else $error("sub clock edge did not tick");

    AST_PRESC_WRAP: assert property (@(posedge clk_sys) disable iff (!rst_s2)
        (ctrl.enable && presc == wtb_pkg::WTB_PRESCALE_LAST) |=> presc == 7'h00)
        else $error("prescaler did not wrap after its last count");


    AST_DIV_COUNT: assert property (@(posedge clk_sys) disable iff (!rst_s2)
        (tick && ctrl.enable) ##1 ctrl.enable |-> div_cnt == $past(div_cnt) + 14'h0001)
        else $error("divider did not advance on watch tick");

    AST_NO_TICK_OFF: assert property (@(posedge clk_sys) disable iff (!rst_s2)
        !ctrl.enable |-> !tick)
        else $error("watch tick while disabled");

    AST_BUZZER_OFF: assert property (@(posedge clk_sys) disable iff (!rst_s2)
        (!ctrl.enable ##1 !ctrl.enable) |=> !buzzer)
        else $error("buzzer active while disabled");


    AST_DISABLE_CLEARS: assert property (@(posedge clk_sys) disable iff (!rst_s2)
        !ctrl.enable |=> (div_cnt == 14'h0000 && presc == 7'h00))
        else $error("dividers not held clear while disabled");
endmodule

// file: testbench/tb_watch_timer_buzzer.sv
// Self-checking bench for the watch timer with buzzer.
// Assumes the register port in the clk_sys domain and a sub clock pin driven here.
`timescale 1ns/1ps
module tb_watch_timer_buzzer;
    localparam logic [7:0] ctrl_a = wtb_pkg::WTB_CTRL_ADDR;
    logic clk_sys, rst_n, sub_clk, reg_wr, reg_rd, irq, buzzer, sub_run;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, rv, model_reg;
    int num_errors = 0, num_checks = 0, cyc = 0, seed, n, p;
    wtb_watch_timer wtb_watch_timer_inst (.clk_sys(clk_sys), .rst_n(rst_n), .sub_clk(sub_clk),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .irq(irq), .buzzer(buzzer));
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    // Sub clock period is 8 system cycles, parked low when not needed
    initial begin
        sub_clk = 1'b0;
        forever begin
            repeat (4) @(posedge clk_sys);
            #1 sub_clk = sub_run & ~sub_clk;
        end
    end
    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            num_errors++;
            test_done();
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    // Writing 0 to the pending bit clears it, writing 1 keeps it
    task automatic wr(input logic [7:0] v);
        @(posedge clk_sys);
        #1 reg_addr = ctrl_a;
        reg_wdata = v;
        reg_wr = 1'b1;
        @(posedge clk_sys);
        #1 reg_wr = 1'b0;
        model_reg = {v[7:1], model_reg[0] & v[0]};
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk_sys);
        #1 reg_addr = a;
        reg_rd = 1'b1;
        @(posedge clk_sys);
        #1 reg_rd = 1'b0;
        rv = reg_rdata;
    endtask
    task automatic wait_for(input bit use_buz, input logic v, input int lim);
        n = 0;
        while ((use_buz ? buzzer : irq) !== v && n < lim) begin
            @(posedge clk_sys);
            #1 n++;
        end
    endtask
    initial begin
        seed = 61531;
        {rst_n, sub_run, reg_wr, reg_rd} = 4'h0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        model_reg = 8'h00;
        repeat (2) @(posedge clk_sys);
        #1 rst_n = 1'b1;
        repeat (3) @(posedge clk_sys);
        rd(ctrl_a);
        chk(rv, 8'h00);
        rd(8'hE7);
        chk(rv, 8'h00);
        // Enable kept off so the random values never start counting
        for (int i = 0; i < 4; i++) begin
            wr(8'($random(seed)) & 8'hFD);
            rd(ctrl_a);
            chk(rv, model_reg);
            chk(irq, 1'b0);
        end
        $display("test registers done");
        wr(8'h4E);
        wait_for(0, 1'b1, 9000);
        chk(32'(n >= 8188 && n <= 8198), 1);
        model_reg[0] = 1'b1;
        wr(8'h0F);
        chk(irq, 1'b0);
        rd(ctrl_a);
        chk(rv, 8'h0F);
        wr(8'h0C);
        rd(ctrl_a);
        chk(rv, model_reg);
        $display("test main clock interval done");
        sub_run = 1'b1;
        for (int s = 3; s >= 2; s--) begin
            wr(8'hC2 | 8'(s << 2));
            wait_for(0, 1'b1, 40000);
            p = (s == 3 ? 64 : 4096) * 8;
            chk(32'(n >= p - 8 && n <= p + 24), 1);
            wr(8'h00);
            chk(irq, 1'b0);
        end
        $display("test sub clock interval done");
        for (int c = 0; c < 4; c++) begin
            wr(8'h82 | 8'(c << 4));
            wait_for(1, 1'b1, 2000);
            wait_for(1, 1'b0, 2000);
            p = n;
            wait_for(1, 1'b1, 2000);
            chk(p + n, (64 >> c) * 8);
            wr(8'h00);
            repeat (3) @(posedge clk_sys);
            #1 chk(buzzer, 1'b0);
        end
        $display("test buzzer done");
        test_done();
    end
endmodule
